// >>> logic/lqm_top.sv
/*
 Link quality monitor: picks a link-up source, filters it through a
 hysteresis timer into a communication-ready indication, counts link
 losses and masked link failures, times the last link training and
 raises a masked interrupt on its events.
 Assumes all inputs synchronous to clk; event inputs are one-cycle
 pulses; rst is the power-up reset.
*/
// Implementation choice: the address-and-strobe port.
// Notes on behaviour
// - link-up comes from the source chosen by the two-bit source field
// - failures count only where their six-bit mask bit is set; mask resets all ones
// - mask bit 5 covers bad signal quality, bit 6 jabber and invalid stream start
// - bit 7 link drop, bit 8 receive error, bit 9 invalid stream end
// - hysteresis time: 00 2 ms, 01 500 us, 10 1 ms, 11 4 ms
// - quality falling below the threshold counts a failure; threshold resets to 100b
// - six-bit read-only count of link losses in bits 15-10
// - ten-bit read-only count of failures without link loss in bits 9-0
// - read-only communication-ready status in bit 15
// - read-only eight-bit duration of the last link training in bits 7-0
`timescale 1ns/1ps
`include "lqm_params.svh"

module lqm_top
#(
   parameter int US_CYCLES = `LQM_CLK_HZ / `LQM_US_PER_S
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic link_up_std,
   input wire logic link_monitor_status,
   input wire logic phy_send_data,
   input wire logic partner_comm_ready,
   input wire logic [2:0] sqi_level,
   input wire logic rx_jabber,
   input wire logic invalid_stream_start,
   input wire logic link_drop_event,
   input wire logic rx_error,
   input wire logic invalid_stream_end,
   input wire logic training_active,
   output logic comm_ready,
   output logic irq
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [15:0] cfg;
   logic [`LQM_LOSS_W-1:0] link_losses;
   logic [`LQM_FAIL_W-1:0] link_failures;
   logic [`LQM_LTT_W-1:0] last_training_duration;
   logic [`LQM_LTT_W-1:0] train_ms;
   logic [9:0] train_us;
   logic training_d;
   logic [`LQM_IRQ_W-1:0] irq_status;
   logic [`LQM_IRQ_W-1:0] irq_mask;
   logic [`LQM_IRQ_W-1:0] irq_events;
   logic [15:0] reg_index;
   logic [6:0] us_div;
   logic us_tick;
   logic [11:0] hyst_us;
   lqm_pkg::lqm_state_t state;
   lqm_pkg::lqm_state_t next_state;
   logic link_up;
   logic sqi_bad;
   logic sqi_bad_d;
   logic [5:0] fail_events;
   logic fail_hit;
   logic loss_hit;
   logic ready_rise;
   logic train_done;
   logic hyst_expired;

   // Decode of the hysteresis time in microseconds
   function automatic logic [11:0] hyst_limit(input logic [1:0] sel);
      logic [11:0] lim;
      lim = `LQM_T_2MS_US;
      case (lqm_pkg::lqm_tmr_t'(sel))
         lqm_pkg::LQM_TMR_2MS: lim = `LQM_T_2MS_US;
         lqm_pkg::LQM_TMR_500US: lim = `LQM_T_500US_US;
         lqm_pkg::LQM_TMR_1MS: lim = `LQM_T_1MS_US;
         lqm_pkg::LQM_TMR_4MS: lim = `LQM_T_4MS_US;
         default: lim = `LQM_T_2MS_US;
      endcase
      return lim;
   endfunction

   // Index from a byte address; low two bits ignored
   function automatic logic [15:0] addr_index(input logic [15:0] a);
      return {2'b00, a[15:2]};
   endfunction

   assign reg_index = addr_index(reg_addr);

   // ****************************************
   // Microsecond enable
   // ****************************************

   // One-cycle pulse per microsecond drives all slow timing
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         us_div <= 7'h00;
         us_tick <= 1'b0;
      end
      else if (us_div == 7'(US_CYCLES - 1))
      begin
         us_div <= 7'h00;
         us_tick <= 1'b1;
      end
      else
      begin
         us_div <= us_div + 7'h01;
         us_tick <= 1'b0;
      end
   end

   // ****************************************
   // Link-up source and hysteresis
   // ****************************************

   // Source select
   always_comb
   begin
      case (lqm_pkg::lqm_src_t'(cfg[`LQM_SRC_HI:`LQM_SRC_LO]))
         lqm_pkg::LQM_SRC_STD: link_up = link_up_std;
         lqm_pkg::LQM_SRC_MONITOR: link_up = link_monitor_status;
         lqm_pkg::LQM_SRC_SEND_DATA: link_up = phy_send_data;
         lqm_pkg::LQM_SRC_COMM_READY: link_up = partner_comm_ready;
         default: link_up = link_up_std;
      endcase
   end

   // Timer compares against the current setting, so a change applies at once
   assign hyst_expired = us_tick &&
      (hyst_us >= hyst_limit(cfg[`LQM_TMR_HI:`LQM_TMR_LO]) - 12'h001);

   // Ready only after the new level has held for the whole hysteresis time
   always_comb
   begin
      next_state = state;
      case (state)
         lqm_pkg::LQM_NOT_READY:
            if (link_up)
               next_state = lqm_pkg::LQM_WAIT_UP;
         lqm_pkg::LQM_WAIT_UP:
            if (!link_up)
               next_state = lqm_pkg::LQM_NOT_READY;
            else if (hyst_expired)
               next_state = lqm_pkg::LQM_READY;
         lqm_pkg::LQM_READY:
            if (!link_up)
               next_state = lqm_pkg::LQM_WAIT_DOWN;
         lqm_pkg::LQM_WAIT_DOWN:
            if (link_up)
               next_state = lqm_pkg::LQM_READY;
            else if (hyst_expired)
               next_state = lqm_pkg::LQM_NOT_READY;
         default:
            next_state = lqm_pkg::LQM_NOT_READY;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state <= lqm_pkg::LQM_NOT_READY;
      else
         state <= next_state;
   end

   // Hysteresis timer, restarted on every state change
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         hyst_us <= 12'h000;
      else if (next_state != state)
         hyst_us <= 12'h000;
      else if (us_tick && hyst_us != 12'hfff)
         hyst_us <= hyst_us + 12'h001;
   end

   // Ready output, also the status bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         comm_ready <= 1'b0;
      else
         comm_ready <= (next_state == lqm_pkg::LQM_READY) ||
            (next_state == lqm_pkg::LQM_WAIT_DOWN);
   end

   assign loss_hit = comm_ready &&
      (state == lqm_pkg::LQM_WAIT_DOWN) && (next_state == lqm_pkg::LQM_NOT_READY);
   assign ready_rise = (state == lqm_pkg::LQM_WAIT_UP) &&
      (next_state == lqm_pkg::LQM_READY);

   // ****************************************
   // Failure detection
   // ****************************************

   // Lower quality value is worse; only the crossing counts
   assign sqi_bad = sqi_level < cfg[`LQM_SQI_HI:`LQM_SQI_LO];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sqi_bad_d <= 1'b0;
      else
         sqi_bad_d <= sqi_bad;
   end

   // Mask bits 5..10 line up with events 0..5; bit 10 has no source
   assign fail_events = {1'b0, invalid_stream_end, rx_error, link_drop_event,
      rx_jabber | invalid_stream_start, sqi_bad & ~sqi_bad_d};

   // Several failures in one cycle count as one; none while a loss ends the link
   assign fail_hit = |(fail_events & cfg[`LQM_FMASK_HI:`LQM_FMASK_LO]) &&
      comm_ready && !loss_hit;

   // ****************************************
   // Counters
   // ****************************************

   // Loss counter, saturating, cleared only at power-up
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         link_losses <= '0;
      else if (loss_hit && link_losses != '1)
         link_losses <= link_losses + 1'b1;
   end

   // Failure counter, saturating
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         link_failures <= '0;
      else if (fail_hit && link_failures != '1)
         link_failures <= link_failures + 1'b1;
   end

   // ****************************************
   // Training duration, in milliseconds
   // ****************************************

   assign train_done = training_d && !training_active;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         training_d <= 1'b0;
      else
         training_d <= training_active;
   end

   // Running duration; saturates so a training of 255 ms or more reads full scale
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         train_us <= 10'h000;
         train_ms <= '0;
      end
      else if (training_active && !training_d)
      begin
         train_us <= 10'h000;
         train_ms <= '0;
      end
      else if (training_active && us_tick)
      begin
         if (train_us == `LQM_US_PER_MS - 10'd1)
         begin
            train_us <= 10'h000;
            if (train_ms != '1)
               train_ms <= train_ms + 1'b1;
         end
         else
            train_us <= train_us + 10'h001;
      end
   end

   // Latched at the end of each training
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         last_training_duration <= '0;
      else if (train_done)
         last_training_duration <= train_ms;
   end

   // ****************************************
   // Registers
   // ****************************************

   // Configuration; read-only bits 15-14 stay zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cfg <= `LQM_CFG_RESET;
      else if (reg_wr && reg_index == `LQM_IDX_CFG)
         cfg <= reg_wdata & `LQM_CFG_WMASK;
   end

   // Interrupt mask
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_mask <= '0;
      else if (reg_wr && reg_index == `LQM_IDX_IRQ_MASK)
         irq_mask <= reg_wdata[`LQM_IRQ_W-1:0];
   end

   // Events: ready up, link loss, failure counted, training done, sqi bad
   assign irq_events = {sqi_bad & ~sqi_bad_d, train_done, fail_hit,
      loss_hit, ready_rise};

   // Sticky status; a new event beats a write-one clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_status <= '0;
      else if (reg_wr && reg_index == `LQM_IDX_IRQ_STATUS)
         irq_status <= (irq_status & ~reg_wdata[`LQM_IRQ_W-1:0]) | irq_events;
      else
         irq_status <= irq_status | irq_events;
   end

   // Level interrupt, registered
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         case (reg_index)
            `LQM_IDX_CFG: reg_rdata <= cfg;
            `LQM_IDX_COUNTS: reg_rdata <= {link_losses, link_failures};
            `LQM_IDX_TRAIN: reg_rdata <= {comm_ready, 7'h00,
               last_training_duration};
            `LQM_IDX_IRQ_STATUS: reg_rdata <= {11'h000, irq_status};
            `LQM_IDX_IRQ_MASK: reg_rdata <= {11'h000, irq_mask};
            default: reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

endmodule

// >>> logic/lqm_params.svh
/*
 Named constants of the link quality monitor: register indices,
 field positions, reset values and timing figures.
 Assumes one 100 MHz clock and word-per-index register addressing.
*/
`ifndef LQM_PARAMS_SVH
`define LQM_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define LQM_IDX_CFG 16'h0560
`define LQM_IDX_COUNTS 16'h0561
`define LQM_IDX_TRAIN 16'h0562
`define LQM_IDX_IRQ_STATUS 16'h0563
`define LQM_IDX_IRQ_MASK 16'h0564

// ****************************************
// Field positions and widths
// ****************************************
`define LQM_CFG_WMASK 16'h3fff
`define LQM_CFG_RESET 16'h07e4
`define LQM_SRC_HI 12
`define LQM_SRC_LO 11
`define LQM_FMASK_HI 10
`define LQM_FMASK_LO 5
`define LQM_TMR_HI 4
`define LQM_TMR_LO 3
`define LQM_SQI_HI 2
`define LQM_SQI_LO 0
`define LQM_LOSS_W 6
`define LQM_FAIL_W 10
`define LQM_LTT_W 8
`define LQM_READY_BIT 15
`define LQM_IRQ_W 5

// ****************************************
// Timing figures
// ****************************************
`define LQM_CLK_HZ 100000000
`define LQM_US_PER_S 1000000
`define LQM_T_2MS_US 12'd2000
`define LQM_T_500US_US 12'd500
`define LQM_T_1MS_US 12'd1000
`define LQM_T_4MS_US 12'd4000
`define LQM_US_PER_MS 10'd1000

`endif

// >>> logic/lqm_pkg.sv
/*
 Types of the link quality monitor.
 Assumes the constants header is compiled alongside.
*/
package lqm_pkg;

   // Hysteresis state, Gray coded along the up and down path
   typedef enum logic [1:0] {
      LQM_NOT_READY = 2'b00,
      LQM_WAIT_UP = 2'b01,
      LQM_READY = 2'b11,
      LQM_WAIT_DOWN = 2'b10
   } lqm_state_t;

   // Link-up source selection
   typedef enum logic [1:0] {
      LQM_SRC_STD = 2'b00,
      LQM_SRC_MONITOR = 2'b01,
      LQM_SRC_SEND_DATA = 2'b10,
      LQM_SRC_COMM_READY = 2'b11
   } lqm_src_t;

   // Hysteresis timer selection
   typedef enum logic [1:0] {
      LQM_TMR_2MS = 2'b00,
      LQM_TMR_500US = 2'b01,
      LQM_TMR_1MS = 2'b10,
      LQM_TMR_4MS = 2'b11
   } lqm_tmr_t;

endpackage

// >>> sim/lqm_top_monitor.sv
/*
 Port checker of the link quality monitor.
 Assumes it is bound to lqm_top; one clock, rst async active high.
*/
`timescale 1ns/1ps
`include "lqm_params.svh"
module lqm_top_monitor
#(
   parameter int US_CYCLES = 100
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic link_up_std,
   input wire logic link_monitor_status,
   input wire logic phy_send_data,
   input wire logic partner_comm_ready,
   input wire logic comm_ready,
   input wire logic irq
);
   // ****************************************
   // Shadow state
   // ****************************************
   logic [15:0] cfg_sh;
   logic [15:0] idx;
   logic [4:0] msk_sh;
   logic [3:0] srcs;
   logic sel;
   int up_n;
   int dn_n;
   int t_cyc;
   assign idx = reg_addr >> 2;
   assign srcs = {partner_comm_ready, phy_send_data, link_monitor_status, link_up_std};
   assign sel = srcs[cfg_sh[12:11]];
   // Mirror of config and mask, fed by the same writes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_sh <= `LQM_CFG_RESET;
         msk_sh <= 5'h00;
      end
      else if (reg_wr && idx == `LQM_IDX_CFG)
         cfg_sh <= reg_wdata & `LQM_CFG_WMASK;
      else if (reg_wr && idx == `LQM_IDX_IRQ_MASK)
         msk_sh <= reg_wdata[4:0];
   end
   // Hold time of the chosen timer, in clocks
   always_comb
   begin
      case (cfg_sh[4:3])
         2'h0: t_cyc = 2000 * US_CYCLES;
         2'h1: t_cyc = 500 * US_CYCLES;
         2'h2: t_cyc = 1000 * US_CYCLES;
         default: t_cyc = 4000 * US_CYCLES;
      endcase
   end
   // Run lengths of the source level; capped so they never wrap
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         up_n <= 0;
         dn_n <= 0;
      end
      else
      begin
         up_n <= sel ? ((up_n < 1000000) ? up_n + 1 : up_n) : 0;
         dn_n <= !sel ? ((dn_n < 1000000) ? dn_n + 1 : dn_n) : 0;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_cfg_read_back: assert property (reg_rd && idx == `LQM_IDX_CFG |=> reg_rdata == $past(cfg_sh))
      else $error("config read mismatch");
   a_train_ready_bit: assert property (reg_rd && idx == `LQM_IDX_TRAIN |=>
      reg_rdata[15:8] == {$past(comm_ready), 7'h00})
      else $error("ready status bit mismatch");
   a_unmapped_zero: assert property (reg_rd && (idx < `LQM_IDX_CFG || idx > `LQM_IDX_IRQ_MASK)
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_ready_not_early: assert property ($rose(comm_ready) |-> up_n >= t_cyc - 2)
      else $error("ready rose before hold time");
   a_ready_not_late: assert property (up_n == t_cyc + US_CYCLES + 4 |-> comm_ready)
      else $error("ready late after source up");
   a_drop_not_early: assert property ($fell(comm_ready) |-> dn_n >= t_cyc - 2)
      else $error("ready fell before hold time");
   a_irq_needs_mask: assert property (irq |-> $past(msk_sh) != 5'h00)
      else $error("irq with all events masked");
endmodule
bind lqm_top lqm_top_monitor #(.US_CYCLES(US_CYCLES)) u_mon (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .link_up_std(link_up_std), .link_monitor_status(link_monitor_status),
   .phy_send_data(phy_send_data), .partner_comm_ready(partner_comm_ready),
   .comm_ready(comm_ready), .irq(irq));

// >>> sim/lqm_partner.sv
/*
 Far-side link model: link-up sources, quality level, fault pulses, training.
 Assumes the bench calls its tasks; all changes land just after a rising edge.
*/
`timescale 1ns/1ps
module lqm_partner
(
   input wire logic clk,
   output logic link_std,
   output logic link_mon,
   output logic send_data,
   output logic peer_ready,
   output logic [2:0] sqi,
   output logic jabber,
   output logic start_bad,
   output logic drop,
   output logic rx_err,
   output logic end_bad,
   output logic training
);
   logic [3:0] link_src;
   logic [4:0] evt;
   // Each source and fault is its own pin, so every design input is exercised
   assign {peer_ready, send_data, link_mon, link_std} = link_src;
   assign {end_bad, rx_err, drop, start_bad, jabber} = evt;
   // Quiet, link down, good quality at time zero
   initial
   begin
      link_src = 4'h0;
      sqi = 3'h7;
      evt = 5'h00;
      training = 1'b0;
   end
   // Only one source moves, so a wrong source pick stalls ready
   task automatic link(input int k, input logic on);
      @(posedge clk);
      link_src <= on ? 4'(1 << k) : 4'h0;
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      evt <= 5'(1 << i);
      @(posedge clk);
      evt <= 5'h00;
   endtask
   task automatic set_sqi(input logic [2:0] q);
      @(posedge clk);
      sqi <= q;
   endtask
   task automatic train(input int n);
      @(posedge clk);
      training <= 1'b1;
      repeat (n) @(posedge clk);
      training <= 1'b0;
   endtask
endmodule

// >>> sim/lqm_bench.sv
/*
 Self-checking bench of the link quality monitor.
 Assumes lqm_top, its bound checker and the far-side model.
*/
`timescale 1ns/1ps
`include "lqm_params.svh"
module lqm_bench;
   localparam int US = 2;
   logic clk, rst, reg_wr, reg_rd, comm_ready, irq, training;
   logic l_std, l_mon, l_send, l_peer, jab, ss_bad, drop, rxe, se_bad;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, v, m;
   logic [2:0] sqi;
   int num_errors, checked, cyc, n;
   int tmr[4] = '{2000, 500, 1000, 4000};
   int mbit[5] = '{1, 1, 2, 3, 4};
   lqm_top #(.US_CYCLES(US)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_up_std(l_std), .link_monitor_status(l_mon), .phy_send_data(l_send),
      .partner_comm_ready(l_peer), .sqi_level(sqi), .rx_jabber(jab),
      .invalid_stream_start(ss_bad), .link_drop_event(drop), .rx_error(rxe),
      .invalid_stream_end(se_bad), .training_active(training), .comm_ready(comm_ready),
      .irq(irq));
   lqm_partner u_far (.clk(clk), .link_std(l_std), .link_mon(l_mon), .send_data(l_send),
      .peer_ready(l_peer), .sqi(sqi), .jabber(jab), .start_bad(ss_bad), .drop(drop),
      .rx_err(rxe), .end_bad(se_bad), .training(training));
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, about twice the expected run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         num_errors++;
         end_sim();
      end
   end
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] i, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= i << 2;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] i);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= i << 2;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_rdy(input logic lvl);
      n = 0;
      while (comm_ready !== lvl && n < 20000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic t_regs();
      rd(`LQM_IDX_CFG);
      cmp("config reset", `LQM_CFG_RESET, v);
      wr(`LQM_IDX_COUNTS, 16'hffff);
      rd(`LQM_IDX_COUNTS);
      cmp("counts", 16'h0000, v);
      wr(`LQM_IDX_TRAIN, 16'hffff);
      rd(`LQM_IDX_TRAIN);
      cmp("train", 16'h0000, v);
      rd(16'h0565);
      cmp("unmapped", 16'h0000, v);
      $display("test regs done");
   endtask
   // Each source with one timer, source k with timer setting k; each fall is one loss
   task automatic t_ready();
      for (int k = 0; k < 4; k++)
      begin
         wr(`LQM_IDX_CFG, 16'(k << 11) | 16'(k << 3) | 16'h07e4);
         u_far.link(k, 1'b1);
         wait_rdy(1'b1);
         cmp("rise", 16'h1, 16'(n >= tmr[k] * US - 1 && n <= tmr[k] * US + US + 3));
         u_far.link(k, 1'b0);
         wait_rdy(1'b0);
         cmp("fall", 16'h1, 16'(n >= tmr[k] * US - 1 && n <= tmr[k] * US + US + 3));
         rd(`LQM_IDX_COUNTS);
         cmp("losses", 16'((k + 1) << 10), v);
      end
      $display("test ready done");
   endtask
   // Each scenario masked then unmasked alone; expect 6 counts
   task automatic t_fail();
      wr(`LQM_IDX_CFG, 16'h0fec);
      u_far.pulse(3);
      u_far.link(1, 1'b1);
      wait_rdy(1'b1);
      for (int i = 0; i < 5; i++)
      begin
         m = 16'h0020 << mbit[i];
         wr(`LQM_IDX_CFG, 16'h080c | (16'h07e0 & ~m));
         u_far.pulse(i);
         wr(`LQM_IDX_CFG, 16'h080c | m);
         u_far.pulse(i);
      end
      wr(`LQM_IDX_CFG, 16'h0fcc);
      u_far.set_sqi(3'h3);
      u_far.set_sqi(3'h7);
      wr(`LQM_IDX_CFG, 16'h082c);
      u_far.set_sqi(3'h4);
      u_far.set_sqi(3'h3);
      u_far.set_sqi(3'h7);
      rd(`LQM_IDX_COUNTS);
      cmp("failures", 16'h1006, v);
      rd(`LQM_IDX_TRAIN);
      cmp("ready status", 16'h8000, v & 16'hff00);
      $display("test fail done");
   endtask
   task automatic t_irq();
      wr(`LQM_IDX_IRQ_STATUS, 16'h001f);
      wr(`LQM_IDX_IRQ_MASK, 16'h0004);
      wr(`LQM_IDX_CFG, 16'h0fec);
      u_far.pulse(3);
      repeat (3) @(posedge clk);
      cmp("irq raised", 16'h0001, {15'h0000, irq});
      wr(`LQM_IDX_IRQ_STATUS, 16'h0004);
      repeat (3) @(posedge clk);
      cmp("irq cleared", 16'h0000, {15'h0000, irq});
      wr(`LQM_IDX_IRQ_MASK, 16'h0000);
      u_far.pulse(3);
      repeat (3) @(posedge clk);
      cmp("irq masked", 16'h0000, {15'h0000, irq});
      rd(`LQM_IDX_IRQ_STATUS);
      cmp("status", 16'h0004, v);
      $display("test irq done");
   endtask
   // Counter holds at its top, then training time in whole ms
   task automatic t_sat_train();
      repeat (1030) u_far.pulse(3);
      rd(`LQM_IDX_COUNTS);
      cmp("failures top", 16'h13ff, v);
      u_far.link(1, 1'b0);
      wait_rdy(1'b0);
      u_far.train(7000);
      repeat (2) @(posedge clk);
      rd(`LQM_IDX_TRAIN);
      cmp("training", 16'h0003, v);
      $display("test saturate and training done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_ready();
      t_fail();
      t_irq();
      t_sat_train();
      end_sim();
   end
endmodule
